// *** rtl/timer8_pkg.sv ***
package timer8_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [2:0] ADDR_CTRL_FIRST  = 3'h0;
    localparam logic [2:0] ADDR_CTRL_SECOND = 3'h1;
    localparam logic [2:0] ADDR_COUNT       = 3'h2;
    localparam logic [2:0] ADDR_CMP_A       = 3'h3;
    localparam logic [2:0] ADDR_CMP_B       = 3'h4;
    localparam logic [2:0] ADDR_FLAGS       = 3'h5;
    localparam logic [2:0] ADDR_MASK        = 3'h6;

    // Field positions in timer_ctrl_first
    localparam int ACT_A_LSB   = 6;
    localparam int ACT_B_LSB   = 4;
    localparam int WAVE_LO_LSB = 0;
    // Field positions in timer_ctrl_second
    localparam int FORCE_A_BIT  = 7;
    localparam int FORCE_B_BIT  = 6;
    localparam int WAVE_HI_BIT  = 3;
    localparam int TICK_SEL_LSB = 0;
    // Bits kept by timer_ctrl_second; force strobes are not stored
    localparam logic [7:0] CTRL2_KEEP = 8'h0F;

    // Flag and mask bit positions
    localparam int FLAG_WRAP = 0;
    localparam int FLAG_A    = 1;
    localparam int FLAG_B    = 2;

    // Values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hFF;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] ONE_VAL    = 8'h01;
    localparam logic [2:0] TICK_STOP   = 3'h0;
    localparam logic [2:0] TICK_DIRECT = 3'h1;

    // Waveform modes
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_PHASE_MAX = 3'h1;
    localparam logic [2:0] MODE_CTC       = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
    localparam logic [2:0] MODE_PHASE_A   = 3'h5;
    localparam logic [2:0] MODE_FAST_A    = 3'h7;

    // Output actions
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    typedef enum logic [1:0] {CLS_NORMAL, CLS_CTC, CLS_FAST, CLS_PHASE}
        wave_class_t;

endpackage

// *** rtl/wave_out_unit.sv ***
`timescale 1ns/10ps
`default_nettype none

module wave_out_unit #(
    parameter bit IS_CHAN_A = 1'b1
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Mode
    input  wire logic       is_fast_i,
    input  wire logic       is_phase_i,
    input  wire logic       high_bit_i,
    input  wire logic [1:0] action_i,
    // Events
    input  wire logic       hit_i,
    input  wire logic       force_i,
    input  wire logic       eq_top_i,
    input  wire logic       down_i,
    input  wire logic       bottom_i,
    input  wire logic       top_i,
    // Waveform register
    output logic            wave_o
);

    logic wave_d;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    ////////////////////////////////////////////////////////////////////
    // Next output level; action bits act unbuffered
    always_comb
    begin
        wave_d = wave_o;
        if (!is_fast_i && !is_phase_i)
        begin
            if (hit_i || force_i) // [RL9] [RL13] [RL16]
            begin
                case (action_i)
                    timer8_pkg::ACT_TOGGLE: wave_d = ~wave_o;
                    timer8_pkg::ACT_CLEAR:  wave_d = 1'b0;
                    timer8_pkg::ACT_SET:    wave_d = 1'b1;
                    default:                wave_d = wave_o;
                endcase
            end
        end
        else if (action_i == timer8_pkg::ACT_TOGGLE)
        begin
            // Only channel A with the high mode bit may toggle
            if (IS_CHAN_A && high_bit_i && hit_i) // [RL18]
                wave_d = ~wave_o;
        end
        else if (action_i[1])
        begin
            if (is_fast_i)
            begin
                if (bottom_i) // [RL17] [RL20]
                    wave_d = ~action_i[0];
                else if (hit_i && !eq_top_i)
                    wave_d = action_i[0];
            end
            else if (eq_top_i)
            begin
                if (top_i) // [RL21]
                    wave_d = ~action_i[0];
            end
            else if (hit_i) // [RL19]
                wave_d = down_i ? ~action_i[0] : action_i[0];
        end
    end

    // Kept across mode changes, zero after reset
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            wave_o <= 1'b0; // [RL14]
        else
            wave_o <= wave_d; // [RL12]
    end

    ////////////////////////////////////////////////////////////////////
    property p_force_toggle;
        !is_fast_i && !is_phase_i && force_i &&
            action_i == timer8_pkg::ACT_TOGGLE |=> wave_o != $past(wave_o);
    endproperty
    a_force_toggle: assert property (p_force_toggle) // [RL9]
        else $error("forced toggle did not flip output");

    property p_off_hold;
        action_i == timer8_pkg::ACT_OFF |=> $stable(wave_o);
    endproperty
    a_off_hold: assert property (p_off_hold) // [RL16]
        else $error("output moved with action off");

endmodule

`default_nettype wire

// *** rtl/timer8_compare_waveform_unit.sv ***
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RL1] Tick select zero stops counter, holds value
// [RL2] CPU reads and writes counter any time
// [RL3] CPU counter write beats count or clear
// [RL4] Three-bit wave mode split across controls
// [RL5] Equality sets match flag at next tick
// [RL6] Flag clears on service or written one
// [RL7] PWM compare values update at TOP/BOTTOM
// [RL8] Writes hit buffer in PWM, else direct
// [RL9] Force strobe acts like match, no flag
// [RL10] Counter write blocks matches next tick
// [RL11] Software avoids writing count equal compare
// [RL12] Waveform registers survive mode changes
// [RL13] Output action bits take effect immediately
// [RL14] Waveform registers reset to zero
// [RL15] Nonzero action overrides port data value
// [RL16] Non-PWM actions: off, toggle, clear, set
// [RL17] Fast PWM: clear/set on match, invert bottom
// [RL18] PWM action one: only A toggles
// [RL19] Phase PWM: up and down actions opposite
// [RL20] Fast PWM compare at TOP acts at BOTTOM
// [RL21] Phase PWM compare at TOP acts at TOP
// [RL22] Mode zero wraps, sets wrap flag
// [RL23] Mode two clears on compare A
// [RL24] Fast PWM modes three and seven
// [RL25] Fast PWM clears tick after reaching TOP
module timer8_compare_waveform_unit (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Register port
    input  wire logic [2:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // Prescaled tick and interrupt service
    input  wire logic       prescale_tick_i,
    input  wire logic [2:0] irq_ack_i,
    output logic      [2:0] irq_o,
    // Port pins, index 0 is channel A
    input  wire logic [1:0] port_data_i,
    input  wire logic [1:0] pin_dir_i,
    output logic      [1:0] pin_val_o,
    output logic      [1:0] pin_oe_n_o,
    // Waveform registers
    output logic            wave_out_a_o,
    output logic            wave_out_b_o
);

    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [7:0] count_q;
    logic [7:0] cmp_a_q;
    logic [7:0] cmp_b_q;
    logic [7:0] buf_a_q;
    logic [7:0] buf_b_q;
    logic [7:0] mask_q;
    logic [2:0] flags_q;
    logic       down_q;
    logic       block_q;
    logic [7:0] rd_mux;

    logic [2:0] wave_mode_sel;
    logic [2:0] tick_source_sel;
    logic [1:0] act_a;
    logic [1:0] act_b;
    logic       timer_tick;
    logic       wr_ctrl1;
    logic       wr_ctrl2;
    logic       wr_count;
    logic       wr_cmp_a;
    logic       wr_cmp_b;
    logic       wr_flags;
    logic       wr_mask;
    timer8_pkg::wave_class_t cls;
    logic       pwm;
    logic [7:0] top_val;
    logic       at_top;
    logic       eq_a;
    logic       eq_b;
    logic       hit_a;
    logic       hit_b;
    logic       fast_wrap;
    logic       pc_top;
    logic       wrap_ev;
    logic       buf_load;
    logic       force_a;
    logic       force_b;
    logic [2:0] flag_set;
    logic [2:0] flag_clr;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // Mode class from the three wave mode bits
    function automatic timer8_pkg::wave_class_t mode_class(
        input logic [2:0] m
    );
        case (m)
            timer8_pkg::MODE_CTC:       mode_class = timer8_pkg::CLS_CTC;
            timer8_pkg::MODE_FAST_MAX,
            timer8_pkg::MODE_FAST_A:    mode_class = timer8_pkg::CLS_FAST;
            timer8_pkg::MODE_PHASE_MAX,
            timer8_pkg::MODE_PHASE_A:   mode_class = timer8_pkg::CLS_PHASE;
            default:                    mode_class = timer8_pkg::CLS_NORMAL;
        endcase
    endfunction

    // Write strobe decode
    function automatic logic wr_at(input logic [2:0] a);
        wr_at = wr_i && (addr_i == a);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decode
    assign wr_ctrl1 = wr_at(timer8_pkg::ADDR_CTRL_FIRST);
    assign wr_ctrl2 = wr_at(timer8_pkg::ADDR_CTRL_SECOND);
    assign wr_count = wr_at(timer8_pkg::ADDR_COUNT);
    assign wr_cmp_a = wr_at(timer8_pkg::ADDR_CMP_A);
    assign wr_cmp_b = wr_at(timer8_pkg::ADDR_CMP_B);
    assign wr_flags = wr_at(timer8_pkg::ADDR_FLAGS);
    assign wr_mask  = wr_at(timer8_pkg::ADDR_MASK);

    // Mode fields, high bit lives in the second control
    assign wave_mode_sel = {ctrl2_q[timer8_pkg::WAVE_HI_BIT],
                            ctrl1_q[timer8_pkg::WAVE_LO_LSB +: 2]}; // [RL4]
    assign tick_source_sel = ctrl2_q[timer8_pkg::TICK_SEL_LSB +: 3];
    assign act_a = ctrl1_q[timer8_pkg::ACT_A_LSB +: 2];
    assign act_b = ctrl1_q[timer8_pkg::ACT_B_LSB +: 2];
    assign cls   = mode_class(wave_mode_sel);
    assign pwm   = (cls == timer8_pkg::CLS_FAST) ||
                   (cls == timer8_pkg::CLS_PHASE);

    // No tick at all when the source is stopped
    always_comb
    begin
        case (tick_source_sel)
            timer8_pkg::TICK_STOP:   timer_tick = 1'b0; // [RL1]
            timer8_pkg::TICK_DIRECT: timer_tick = 1'b1;
            default:                 timer_tick = prescale_tick_i;
        endcase
    end

    // TOP is compare A in modes 2, 5 and 7, else MAX
    assign top_val = (wave_mode_sel == timer8_pkg::MODE_CTC ||
                      wave_mode_sel == timer8_pkg::MODE_PHASE_A ||
                      wave_mode_sel == timer8_pkg::MODE_FAST_A) ?
                     cmp_a_q : timer8_pkg::MAX_VAL; // [RL23] [RL24]
    assign at_top = (count_q == top_val);

    // Comparators; a counter write blocks the next tick's match
    assign eq_a  = (count_q == cmp_a_q);
    assign eq_b  = (count_q == cmp_b_q);
    assign hit_a = timer_tick && eq_a && !block_q; // [RL5] [RL10]
    assign hit_b = timer_tick && eq_b && !block_q;

    assign fast_wrap = timer_tick && (cls == timer8_pkg::CLS_FAST) && at_top;
    assign pc_top    = timer_tick && (cls == timer8_pkg::CLS_PHASE) &&
                       !down_q && at_top;
    assign buf_load  = pwm && (fast_wrap || pc_top); // [RL7]

    // Wrap event per mode family
    always_comb
    begin
        case (cls)
            timer8_pkg::CLS_PHASE:
                wrap_ev = down_q && (count_q == timer8_pkg::BOTTOM_VAL);
            timer8_pkg::CLS_FAST:
                wrap_ev = at_top;
            default:
                wrap_ev = (count_q == timer8_pkg::MAX_VAL); // [RL22]
        endcase
        wrap_ev = wrap_ev && timer_tick && !wr_count;
    end

    // Force strobes act only outside PWM [RL9]
    assign force_a = wr_ctrl2 && wdata_i[timer8_pkg::FORCE_A_BIT] && !pwm;
    assign force_b = wr_ctrl2 && wdata_i[timer8_pkg::FORCE_B_BIT] && !pwm;

    ////////////////////////////////////////////////////////////////////
    // Counter: CPU write first, then the mode's step
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            count_q <= timer8_pkg::RST_BYTE;
        else if (wr_count)
            count_q <= wdata_i; // [RL2] [RL3]
        else if (timer_tick)
        begin
            case (cls)
                timer8_pkg::CLS_FAST: // [RL25]
                    count_q <= at_top ? timer8_pkg::BOTTOM_VAL :
                               count_q + timer8_pkg::ONE_VAL;
                timer8_pkg::CLS_CTC: // [RL23]
                    count_q <= eq_a ? timer8_pkg::BOTTOM_VAL :
                               count_q + timer8_pkg::ONE_VAL;
                timer8_pkg::CLS_PHASE:
                    if (down_q == (count_q == timer8_pkg::BOTTOM_VAL) &&
                        !(!down_q && at_top))
                        count_q <= count_q + timer8_pkg::ONE_VAL;
                    else
                        count_q <= count_q - timer8_pkg::ONE_VAL;
                default:
                    count_q <= count_q + timer8_pkg::ONE_VAL; // [RL22]
            endcase
        end
    end

    // Phase-correct direction turns at TOP and BOTTOM
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            down_q <= 1'b0;
        else if (cls != timer8_pkg::CLS_PHASE)
            down_q <= 1'b0;
        else if (timer_tick && !down_q && at_top)
            down_q <= 1'b1;
        else if (timer_tick && down_q &&
                 count_q == timer8_pkg::BOTTOM_VAL)
            down_q <= 1'b0;
    end

    // Match blocking lasts until the next tick, even when stopped
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            block_q <= 1'b0;
        else if (wr_count)
            block_q <= 1'b1; // [RL10]
        else if (timer_tick)
            block_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Control and mask registers
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ctrl1_q <= timer8_pkg::RST_BYTE;
            ctrl2_q <= timer8_pkg::RST_BYTE;
            mask_q  <= timer8_pkg::RST_BYTE;
        end
        else
        begin
            if (wr_ctrl1)
                ctrl1_q <= wdata_i; // [RL13]
            if (wr_ctrl2)
                ctrl2_q <= wdata_i & timer8_pkg::CTRL2_KEEP;
            if (wr_mask)
                mask_q <= wdata_i;
        end
    end

    // Compare values: buffered in PWM, direct otherwise
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            buf_a_q <= timer8_pkg::RST_BYTE;
            buf_b_q <= timer8_pkg::RST_BYTE;
            cmp_a_q <= timer8_pkg::RST_BYTE;
            cmp_b_q <= timer8_pkg::RST_BYTE;
        end
        else
        begin
            if (wr_cmp_a)
                buf_a_q <= wdata_i; // [RL8]
            if (wr_cmp_b)
                buf_b_q <= wdata_i;
            if (buf_load)
            begin
                cmp_a_q <= buf_a_q; // [RL7]
                cmp_b_q <= buf_b_q;
            end
            else if (!pwm)
            begin
                if (wr_cmp_a)
                    cmp_a_q <= wdata_i; // [RL8]
                if (wr_cmp_b)
                    cmp_b_q <= wdata_i;
            end
        end
    end

    // Flags: hardware set wins over a same-cycle clear
    assign flag_set = {hit_b, hit_a, wrap_ev}; // [RL5]
    assign flag_clr = irq_ack_i | (wr_flags ? wdata_i[2:0] : 3'h0); // [RL6]

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            flags_q <= 3'h0;
        else
            flags_q <= (flags_q & ~flag_clr) | flag_set;
    end

    // Requests follow enabled flags one cycle later
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_o <= 3'h0;
        else
            irq_o <= flags_q & mask_q[2:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Read data valid only in the cycle after the strobe
    always_comb
    begin
        case (addr_i)
            timer8_pkg::ADDR_CTRL_FIRST:  rd_mux = ctrl1_q;
            timer8_pkg::ADDR_CTRL_SECOND: rd_mux = ctrl2_q;
            timer8_pkg::ADDR_COUNT:       rd_mux = count_q; // [RL2]
            timer8_pkg::ADDR_CMP_A:       rd_mux = buf_a_q; // [RL8]
            timer8_pkg::ADDR_CMP_B:       rd_mux = buf_b_q;
            timer8_pkg::ADDR_FLAGS:       rd_mux = {5'h00, flags_q};
            timer8_pkg::ADDR_MASK:        rd_mux = mask_q;
            default:                      rd_mux = timer8_pkg::RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rdata_o <= timer8_pkg::RST_BYTE;
        else
            rdata_o <= rd_i ? rd_mux : timer8_pkg::RST_BYTE;
    end

    ////////////////////////////////////////////////////////////////////
    // Waveform generators, one per channel
    wave_out_unit #(.IS_CHAN_A(1'b1)) u_wave_a (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .is_fast_i  (cls == timer8_pkg::CLS_FAST),
        .is_phase_i (cls == timer8_pkg::CLS_PHASE),
        .high_bit_i (wave_mode_sel[2]),
        .action_i   (act_a), // [RL16] [RL17] [RL18] [RL19]
        .hit_i      (hit_a),
        .force_i    (force_a),
        .eq_top_i   (cmp_a_q == top_val), // [RL20] [RL21]
        .down_i     (down_q),
        .bottom_i   (fast_wrap),
        .top_i      (pc_top),
        .wave_o     (wave_out_a_o) // [RL12] [RL14]
    );

    wave_out_unit #(.IS_CHAN_A(1'b0)) u_wave_b (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .is_fast_i  (cls == timer8_pkg::CLS_FAST),
        .is_phase_i (cls == timer8_pkg::CLS_PHASE),
        .high_bit_i (wave_mode_sel[2]),
        .action_i   (act_b),
        .hit_i      (hit_b),
        .force_i    (force_b),
        .eq_top_i   (cmp_b_q == top_val),
        .down_i     (down_q),
        .bottom_i   (fast_wrap),
        .top_i      (pc_top),
        .wave_o     (wave_out_b_o)
    );

    // Port override; direction stays with the port's own bit
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pin_val_o  <= 2'h0;
            pin_oe_n_o <= 2'h3;
        end
        else
        begin
            pin_val_o[0] <= (act_a != timer8_pkg::ACT_OFF) ?
                            wave_out_a_o : port_data_i[0]; // [RL15]
            pin_val_o[1] <= (act_b != timer8_pkg::ACT_OFF) ?
                            wave_out_b_o : port_data_i[1];
            pin_oe_n_o   <= ~pin_dir_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    property p_stop_hold;
        tick_source_sel == timer8_pkg::TICK_STOP && !wr_count
            |=> $stable(count_q);
    endproperty
    a_stop_hold: assert property (p_stop_hold) // [RL1]
        else $error("counter moved while stopped");

    property p_cpu_wins;
        wr_count |=> count_q == $past(wdata_i);
    endproperty
    a_cpu_wins: assert property (p_cpu_wins) // [RL3]
        else $error("counter write lost");

    // Checker's own note of a counter write still awaiting its tick
    logic pend_q;

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pend_q <= 1'b0;
        else if (wr_count)
            pend_q <= 1'b1;
        else if (timer_tick)
            pend_q <= 1'b0;
    end

    sequence s_write_then_tick;
        pend_q && timer_tick && eq_b && !wr_count;
    endsequence
    property p_block;
        s_write_then_tick ##0 !flags_q[timer8_pkg::FLAG_B]
            |=> !flags_q[timer8_pkg::FLAG_B];
    endproperty
    a_block: assert property (p_block) // [RL10]
        else $error("match not blocked after counter write");

    property p_flag_set;
        hit_a |=> flags_q[timer8_pkg::FLAG_A];
    endproperty
    a_flag_set: assert property (p_flag_set) // [RL5]
        else $error("match flag not set");

    property p_flag_clear;
        irq_ack_i[timer8_pkg::FLAG_A] && !hit_a
            |=> !flags_q[timer8_pkg::FLAG_A];
    endproperty
    a_flag_clear: assert property (p_flag_clear) // [RL6]
        else $error("serviced flag not cleared");

    property p_direct;
        !pwm && wr_cmp_a |=> cmp_a_q == $past(wdata_i);
    endproperty
    a_direct: assert property (p_direct) // [RL8]
        else $error("direct compare write lost");

    property p_buffered;
        pwm && !buf_load |=> $stable(cmp_a_q);
    endproperty
    a_buffered: assert property (p_buffered) // [RL7]
        else $error("active compare changed off TOP/BOTTOM");

    property p_wrap;
        cls == timer8_pkg::CLS_NORMAL && timer_tick && !wr_count &&
            count_q == timer8_pkg::MAX_VAL
            |=> count_q == timer8_pkg::BOTTOM_VAL &&
                flags_q[timer8_pkg::FLAG_WRAP];
    endproperty
    a_wrap: assert property (p_wrap) // [RL22]
        else $error("normal mode wrap wrong");

    property p_fast_clear;
        fast_wrap && !wr_count |=> count_q == timer8_pkg::BOTTOM_VAL;
    endproperty
    a_fast_clear: assert property (p_fast_clear) // [RL25]
        else $error("fast PWM did not clear after TOP");

endmodule

`default_nettype wire

// *** bench/timer8_compare_waveform_unit_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module timer8_compare_waveform_unit_test;
    logic       clk_i, nrst_i, wr_i, rd_i, prescale_tick_i;
    logic [2:0] addr_i, irq_ack_i, irq_o;
    logic [7:0] wdata_i, rdata_o, v;
    logic [1:0] port_data_i, pin_dir_i, pin_val_o, pin_oe_n_o;
    logic       wave_out_a_o, wave_out_b_o;
    int         bad_count, compares, m, a, c, d, h;
    int         modes[5] = '{3, 3, 1, 2, 7};
    int         acts[5]  = '{2, 3, 2, 1, 1};

    timer8_compare_waveform_unit uut (
        .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .prescale_tick_i(prescale_tick_i), .irq_ack_i(irq_ack_i),
        .irq_o(irq_o), .port_data_i(port_data_i), .pin_dir_i(pin_dir_i),
        .pin_val_o(pin_val_o), .pin_oe_n_o(pin_oe_n_o),
        .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o));

    ////////////////////////////////////////////////////////////////////////
    // Clock, 4 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic results;
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Gap after each strobe keeps one assignment per signal per edge
    task automatic wr(input logic [2:0] ad, input logic [7:0] dt);
        @(posedge clk_i);
        addr_i  <= ad;
        wdata_i <= dt;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rdc(input logic [2:0] ad, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask

    // Rise-to-rise period of wave A and its high time in that period
    task automatic per(output int pd, output int hi);
        int   n, k;
        logic p, w;
        begin
            pd = 0;
            hi = 0;
            n  = 0;
            k  = 0;
            p  = wave_out_a_o;
            while (k < 2 && n < 1200)
            begin
                @(posedge clk_i);
                #1 w = wave_out_a_o;
                n++;
                if (w && !p)
                begin
                    k++;
                    if (k == 2)
                        pd = n;
                    n = 0;
                end
                if (w && k == 1)
                    hi++;
                p = w;
            end
        end
    endtask

    // Expected waveform figures, one tick per clock
    function automatic int exp_per(input int md, input int cv);
        case (md)
            1: return 510;
            3: return 256;
            default: return 2 * (cv + 1);
        endcase
    endfunction

    function automatic int exp_high(input int md, input int ac, input int cv);
        case (md)
            1: return (ac == 2) ? 2 * cv : 510 - 2 * cv;
            3: return (ac == 2) ? cv + 1 : 255 - cv;
            default: return cv + 1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Watchdog, several times the expected run
    initial
    begin
        #150000;
        bad_count++;
        results();
    end

    // Main sequence
    initial
    begin
        {wr_i, rd_i, prescale_tick_i, nrst_i} = 4'h0;
        {addr_i, irq_ack_i, wdata_i} = 14'h0000;
        bad_count = 0;
        compares  = 0;
        void'($urandom(32'h93557344));
        port_data_i = 2'($urandom);
        pin_dir_i   = 2'($urandom);
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(3'(i), 8'h00);
        chk({wave_out_b_o, wave_out_a_o}, 2'b00);
        chk(pin_oe_n_o, 2'(~pin_dir_i));
        // Stopped counter keeps a written value
        v = 8'($urandom_range(200, 16));
        wr(timer8_pkg::ADDR_COUNT, v);
        repeat (6) @(posedge clk_i);
        rdc(timer8_pkg::ADDR_COUNT, v);
        // Compare B equals written count, so its first match is blocked
        wr(timer8_pkg::ADDR_CMP_A, v + 8'h05);
        wr(timer8_pkg::ADDR_CMP_B, v);
        wr(timer8_pkg::ADDR_MASK, 8'h07);
        wr(timer8_pkg::ADDR_COUNT, v);
        wr(timer8_pkg::ADDR_CTRL_SECOND, 8'h01);
        repeat (10) @(posedge clk_i);
        wr(timer8_pkg::ADDR_CTRL_SECOND, 8'h00);
        rdc(timer8_pkg::ADDR_FLAGS, 8'h02);
        chk(irq_o, 3'b010);
        @(posedge clk_i);
        irq_ack_i <= 3'b010;
        @(posedge clk_i);
        irq_ack_i <= 3'b000;
        rdc(timer8_pkg::ADDR_FLAGS, 8'h00);
        wr(timer8_pkg::ADDR_COUNT, 8'hF8);
        wr(timer8_pkg::ADDR_CTRL_SECOND, 8'h01);
        repeat (10) @(posedge clk_i);
        wr(timer8_pkg::ADDR_CTRL_SECOND, 8'h00);
        rdc(timer8_pkg::ADDR_FLAGS, 8'h01);
        wr(timer8_pkg::ADDR_FLAGS, 8'h01);
        rdc(timer8_pkg::ADDR_FLAGS, 8'h00);
        // Forced matches walk toggle, clear, set on both channels
        for (int i = 0; i < 5; i++)
        begin
            a = (i == 4) ? 3 : i % 3 + 1;
            wr(timer8_pkg::ADDR_CTRL_FIRST, {a[1:0], a[1:0], 4'h0});
            wr(timer8_pkg::ADDR_CTRL_SECOND, 8'hC0);
            repeat (2) @(posedge clk_i);
            chk({wave_out_b_o, wave_out_a_o}, {2{~i[0]}});
            chk(pin_val_o, {2{~i[0]}});
        end
        rdc(timer8_pkg::ADDR_FLAGS, 8'h00);
        wr(timer8_pkg::ADDR_CTRL_FIRST, 8'h03);
        repeat (2) @(posedge clk_i);
        chk({wave_out_b_o, wave_out_a_o}, 2'b11);
        chk(pin_val_o, port_data_i);
        // Running waveforms in PWM and clear-on-match modes
        for (int i = 0; i < 5; i++)
        begin
            m = modes[i];
            a = acts[i];
            c = $urandom_range(100, 16);
            wr(timer8_pkg::ADDR_CTRL_SECOND, 8'h00);
            wr(timer8_pkg::ADDR_CTRL_FIRST, {a[1:0], 4'h0, m[1:0]});
            wr(timer8_pkg::ADDR_CMP_A, 8'(c));
            wr(timer8_pkg::ADDR_CTRL_SECOND, {4'h0, m[2], 3'h1});
            per(d, h);
            per(d, h);
            chk(16'(d), 16'(exp_per(m, c)));
            chk(16'(h > exp_high(m, a, c) - 3 && h < exp_high(m, a, c) + 3),
                16'h0001);
        end
        results();
    end
endmodule

`default_nettype wire
